// ===== src/dprr_regs.svh
`ifndef DPRR_REGS_SVH
`define DPRR_REGS_SVH

// Register byte offsets
`define DPRR_CTL_BASE     12'hb00
`define DPRR_STATE_BASE   12'hb80
`define DPRR_FEATURE_ID   12'hc00
`define DPRR_RST_REQ      12'hc18
`define DPRR_RST_ACK      12'hc1c

// Block select: address bits above the 32-word window
`define DPRR_BLK_HI       11
`define DPRR_BLK_LO       7
`define DPRR_IDX_HI       6
`define DPRR_IDX_LO       2

// Field positions
`define DPRR_CTL_PRESENT  0
`define DPRR_CTL_REQ      1
`define DPRR_RST_BIT      0
`define DPRR_FID_RST      5
`define DPRR_FID_VER_HI   3
`define DPRR_FID_VER_LO   0

// Field values
`define DPRR_VER_NONE     4'h0
`define DPRR_VER_ONE      4'h1
`define DPRR_CODE_OFF     2'h0
`define DPRR_CODE_ON      2'h1
`define DPRR_CODE_HELD    2'h3
`define DPRR_CODE_RSVD    2'h2

// Reset values and the one-hot domain base
`define DPRR_WORD_ZERO    32'h0000_0000
`define DPRR_DOM_ZERO     32'h0000_0000
`define DPRR_DOM_ONE      32'h0000_0001

`endif

// ===== src/dprr_pkg.sv
package dprr_pkg;
  typedef logic [31:0] dprr_word_t;
  typedef logic [11:0] dprr_addr_t;
  typedef logic [4:0]  dprr_idx_t;
  typedef logic [1:0]  dprr_code_t;
  typedef logic [3:0]  dprr_sel_t;
endpackage

// ===== src/dprr_top.sv
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "dprr_regs.svh"

// Contract
// - One control word per domain, 32 domains
// - Control bit 1 requests domain power
// - Request bit reserved when domain absent
// - Control bit 0 reads domain presence
// - Read-only state word per present domain
// - State code: off, on, reserved, held
// - Only one powered encoding ever reported
// - Keep power while request set, code on
// - Handshake raises held, clears after withdrawal
// - Power never removed between held and clear
// - Unpowerable domain stays at code off
// - Reset request bit sticks until written 0
// - Reset ack reads 1 once reset done
// - Power-on reset clears reset request, ack
// - Reset requests ignored without invasive debug
// - Reset reach fixed at design time
// - Reset registers exist only when feature set
// - Feature word bit 5 shows reset support
// - Feature version 1 when power registers exist
// - Power requests ignored when debug disabled
module dprr_top #(
  parameter logic [31:0] DOM_PRESENT   = 32'h0000_000f,
  parameter bit          PWR_IMPL      = 1'b1,
  parameter bit          PWR_HANDSHAKE = 1'b1,
  parameter bit          RST_IMPL      = 1'b1,
  parameter bit          RST_WHOLE_SYS = 1'b1
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire dprr_pkg::dprr_addr_t wb_adr_i,
  input  wire dprr_pkg::dprr_sel_t  wb_sel_i,
  input  wire dprr_pkg::dprr_word_t wb_dat_i,
  output dprr_pkg::dprr_word_t   wb_dat_o,
  output logic                   wb_ack_o,
  output dprr_pkg::dprr_word_t   pwr_req_o,
  input  wire dprr_pkg::dprr_word_t pwr_on_i,
  output logic                   sys_rst_req_o,
  input  wire logic              sys_rst_done_i,
  input  wire logic              dbg_en_i,
  input  wire logic              invasive_en_i
);
  import dprr_pkg::*;

  // Effective presence mask, empty without power request support
  localparam dprr_word_t PRESENT = PWR_IMPL ? DOM_PRESENT : `DPRR_DOM_ZERO;

  // Block select on the upper address bits
  function automatic logic blk_is(input dprr_addr_t adr, input dprr_addr_t base);
    blk_is = (adr[`DPRR_BLK_HI:`DPRR_BLK_LO] == base[`DPRR_BLK_HI:`DPRR_BLK_LO]);
  endfunction

  // One-hot mask of the addressed domain
  function automatic dprr_word_t dom_mask(input dprr_idx_t idx);
    dom_mask = `DPRR_DOM_ONE << idx;
  endfunction

  // Input synchronisers, two stages each
  dprr_word_t pwr_on_m;
  dprr_word_t pwr_on_s;
  logic       done_m;
  logic       done_s;
  logic       dbg_m;
  logic       dbg_s;
  logic       inv_m;
  logic       inv_s;

  always_ff @(posedge clk_i) begin
    pwr_on_m <= pwr_on_i;
    pwr_on_s <= pwr_on_m;
    done_m   <= sys_rst_done_i;
    done_s   <= done_m;
    dbg_m    <= dbg_en_i;
    dbg_s    <= dbg_m;
    inv_m    <= invasive_en_i;
    inv_s    <= inv_m;
  end

  // Bus decode
  wire        req_taken = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr_lo     = req_taken & wb_we_i & wb_sel_i[0];
  wire        rd        = req_taken & ~wb_we_i;
  dprr_idx_t  idx;
  assign idx = wb_adr_i[`DPRR_IDX_HI:`DPRR_IDX_LO];
  wire        ctl_hit   = blk_is(wb_adr_i, `DPRR_CTL_BASE);
  wire        state_hit = blk_is(wb_adr_i, `DPRR_STATE_BASE);
  wire        fid_hit   = (wb_adr_i == `DPRR_FEATURE_ID);
  wire        rreq_hit  = RST_IMPL && (wb_adr_i == `DPRR_RST_REQ);
  wire        rack_hit  = RST_IMPL && (wb_adr_i == `DPRR_RST_ACK);
  wire        dom_here  = PRESENT[idx];
  wire        wr_bit1   = wb_dat_i[`DPRR_CTL_REQ];
  wire        wr_bit0   = wb_dat_i[`DPRR_RST_BIT];

  // Control and status state
  dprr_word_t pwr_req;
  dprr_word_t pwr_held;
  logic       rst_req;
  logic       rst_ack;

  // per-domain write mask, absent domains dropped
  // no request storage for an absent domain
  dprr_word_t wr_ctl_mask;
  assign wr_ctl_mask = (wr_lo && ctl_hit) ? (dom_mask(idx) & PRESENT) : `DPRR_DOM_ZERO;

  // set and clear of the request bit
  dprr_word_t req_set;
  dprr_word_t req_clr;
  dprr_word_t next_pwr_req;
  assign req_set      = wr_ctl_mask & {32{wr_bit1 & dbg_s}};
  assign req_clr      = wr_ctl_mask & {32{~wr_bit1}};
  assign next_pwr_req = ((pwr_req & ~req_clr) | req_set) & PRESENT;

  // held raised on request plus power, dropped after withdrawal
  // without power the code never leaves off
  dprr_word_t next_held;
  assign next_held = PWR_HANDSHAKE ?
                     (((pwr_req & pwr_on_s) | (pwr_held & (pwr_req | pwr_on_s))) & PRESENT) :
                     `DPRR_DOM_ZERO;

  // reset request sticks until written 0
  wire rst_wr     = wr_lo & rreq_hit;
  wire next_rst_req = rst_wr ? (wr_bit0 & (inv_s | rst_req))
                             : rst_req;

  // ack follows completion, only while request stands
  wire next_rst_ack = next_rst_req & (rst_ack | done_s);

  // power-on reset clears request and ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_req  <= `DPRR_DOM_ZERO;
      pwr_held <= `DPRR_DOM_ZERO;
      rst_req  <= 1'b0;
      rst_ack  <= 1'b0;
    end else begin
      pwr_req  <= next_pwr_req;
      pwr_held <= next_held;
      rst_req  <= next_rst_req;
      rst_ack  <= next_rst_ack;
    end
  end

  // request output stays up while the bit is set
  // power held until the debugger clears the bit
  // reset reach is the fixed parameter RST_WHOLE_SYS
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_req_o     <= `DPRR_DOM_ZERO;
      sys_rst_req_o <= 1'b0;
    end else begin
      pwr_req_o     <= next_pwr_req;
      sys_rst_req_o <= next_rst_req;
    end
  end

  // handshake builds report held only, others on only
  dprr_code_t state_code;
  assign state_code = !dom_here ? `DPRR_CODE_OFF :
                      PWR_HANDSHAKE ? (pwr_held[idx] ? `DPRR_CODE_HELD : `DPRR_CODE_OFF) :
                      (pwr_on_s[idx] ? `DPRR_CODE_ON : `DPRR_CODE_OFF);

  dprr_word_t fid_word;
  assign fid_word = `DPRR_WORD_ZERO |
                    (dprr_word_t'(RST_IMPL) << `DPRR_FID_RST) |
                    dprr_word_t'(PWR_IMPL ? `DPRR_VER_ONE : `DPRR_VER_NONE);

  // state word zero for absent domains
  // reset words read zero when unsupported
  // reserved bits and unmapped addresses read zero
  dprr_word_t ctl_word;
  dprr_word_t state_word;
  dprr_word_t rd_data;
  assign ctl_word   = `DPRR_WORD_ZERO | (dprr_word_t'(dom_here) << `DPRR_CTL_PRESENT) |
                      (dprr_word_t'(pwr_req[idx]) << `DPRR_CTL_REQ);
  assign state_word = `DPRR_WORD_ZERO | dprr_word_t'(state_code);
  assign rd_data    = ctl_hit   ? ctl_word :
                      state_hit ? state_word :
                      fid_hit   ? fid_word :
                      rreq_hit  ? (dprr_word_t'(rst_req) << `DPRR_RST_BIT) :
                      rack_hit  ? (dprr_word_t'(rst_ack) << `DPRR_RST_BIT) :
                      `DPRR_WORD_ZERO;

  // Wishbone answer, one wait state, every address acknowledged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `DPRR_WORD_ZERO;
    end else begin
      wb_ack_o <= req_taken;
      wb_dat_o <= rd ? rd_data : `DPRR_WORD_ZERO;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ctl_write_one;
    wr_lo && ctl_hit && wr_bit1 && dom_here && dbg_s;
  endsequence

  sequence s_rst_write_one;
    rst_wr && wr_bit0 && inv_s;
  endsequence

  sequence s_rst_write_zero;
    rst_wr && !wr_bit0;
  endsequence

  sequence s_ctl_write_zero;
    wr_lo && ctl_hit && !wr_bit1 && dom_here;
  endsequence

  sequence s_rst_blocked;
    rst_wr && wr_bit0 && !inv_s && !rst_req;
  endsequence

  a_bus_answer: assert property (
    req_taken |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle after request");

  a_req_set: assert property (
    s_ctl_write_one |=> pwr_req[$past(idx)] && pwr_req_o[$past(idx)])
    else $error("request bit not set by write");

  a_absent_quiet: assert property (
    (pwr_req_o & ~PRESENT) == `DPRR_DOM_ZERO)
    else $error("request driven for absent domain");

  a_present_read: assert property (
    (rd && ctl_hit) |=> wb_dat_o[`DPRR_CTL_PRESENT] == $past(dom_here))
    else $error("presence bit wrong on read");

  a_absent_state: assert property (
    (rd && state_hit && !dom_here) |=> wb_dat_o == `DPRR_WORD_ZERO)
    else $error("state of absent domain not zero");

  a_code_legal: assert property (
    (rd && state_hit) |=> wb_dat_o[1:0] != `DPRR_CODE_RSVD)
    else $error("reserved state code reported");

  a_one_encoding: assert property (
    (rd && state_hit) |=> wb_dat_o[1:0] != (PWR_HANDSHAKE ? `DPRR_CODE_ON : `DPRR_CODE_HELD))
    else $error("second powered encoding reported");

  a_held_power: assert property (
    (|(pwr_held & pwr_req & ~next_pwr_req)) |-> (wr_lo && ctl_hit && !wr_bit1))
    else $error("power dropped while held without clear");

  a_held_cause: assert property (
    (pwr_held & ~$past(pwr_held) & ~$past(pwr_on_s & pwr_req)) == `DPRR_DOM_ZERO)
    else $error("held raised without power and request");

  a_rst_sticky: assert property (
    (rst_req && !rst_wr) |=> rst_req && sys_rst_req_o)
    else $error("reset request dropped without write");

  a_rst_clear: assert property (
    s_rst_write_zero |=> !rst_req ##1 !sys_rst_req_o)
    else $error("reset request not cleared by write of 0");

  a_rst_set: assert property (
    s_rst_write_one |=> rst_req)
    else $error("reset request not set by write");

  a_ack_needs_req: assert property (
    !rst_req |-> !rst_ack)
    else $error("reset ack without request");

  a_ack_raise: assert property (
    (rst_req && done_s && !rst_wr) |=> rst_ack)
    else $error("reset ack not raised on completion");

  a_por_clear: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> !rst_req && !rst_ack && !sys_rst_req_o)
    else $error("reset bits not cleared by reset");

  a_rst_gate: assert property (
    $rose(rst_req) |-> $past(inv_s))
    else $error("reset request taken while invasive debug off");

  a_fid_read: assert property (
    (rd && fid_hit) |=> wb_dat_o[`DPRR_FID_RST] == RST_IMPL &&
                        wb_dat_o[`DPRR_FID_VER_HI:`DPRR_FID_VER_LO] == (PWR_IMPL ? `DPRR_VER_ONE : `DPRR_VER_NONE))
    else $error("feature word wrong");

  a_pwr_gate: assert property (
    (|(pwr_req & ~$past(pwr_req))) |-> $past(dbg_s))
    else $error("power request taken while debug off");

  a_rsvd_zero: assert property (
    (rd && (rreq_hit || rack_hit)) |=> wb_dat_o[31:1] == 31'h0000_0000)
    else $error("reserved bits not zero");

  // Read data idles at zero between answers
  a_dat_idle: assert property (
    !rd |=> wb_dat_o == `DPRR_WORD_ZERO)
    else $error("read data not zero outside answer");

  a_req_clear: assert property (
    s_ctl_write_zero |=> !pwr_req[$past(idx)] && !pwr_req_o[$past(idx)])
    else $error("request bit not cleared by write of 0");

  a_dbg_block: assert property (
    (wr_lo && ctl_hit && wr_bit1 && !dbg_s && !pwr_req[idx]) |=> !pwr_req[$past(idx)])
    else $error("power request set while debug off");

  a_inv_block: assert property (
    s_rst_blocked |=> !rst_req)
    else $error("reset request set while invasive debug off");

  a_held_drop: assert property (
    (|(pwr_held & ~pwr_req & ~pwr_on_s)) |=> (pwr_held & $past(pwr_held & ~pwr_req & ~pwr_on_s)) == `DPRR_DOM_ZERO)
    else $error("held code kept after withdrawal");

  a_held_raise: assert property (
    (PWR_HANDSHAKE && (|(pwr_req & pwr_on_s))) |=> ($past(pwr_req & pwr_on_s) & ~pwr_held) == `DPRR_DOM_ZERO)
    else $error("held code not raised on power");

  a_held_supply: assert property (
    ((|(pwr_held & pwr_req_o)) && !(wr_lo && ctl_hit)) |=>
      (pwr_req_o & $past(pwr_held & pwr_req_o)) == $past(pwr_held & pwr_req_o))
    else $error("power request dropped while held");

  a_out_match: assert property (
    pwr_req_o == pwr_req && sys_rst_req_o == rst_req)
    else $error("request outputs differ from register bits");

  a_state_read: assert property (
    (rd && state_hit && dom_here && PWR_HANDSHAKE) |=>
      wb_dat_o[1:0] == ($past(pwr_held[idx]) ? `DPRR_CODE_HELD : `DPRR_CODE_OFF))
    else $error("state code does not match handshake");

  a_ctl_rsvd: assert property (
    (rd && ctl_hit) |=> wb_dat_o[31:2] == 30'h0000_0000)
    else $error("control word reserved bits not zero");

  a_absent_ctl: assert property (
    (rd && ctl_hit && !dom_here) |=> wb_dat_o == `DPRR_WORD_ZERO)
    else $error("absent domain control word not zero");

  a_ack_clear: assert property (
    s_rst_write_zero |=> !rst_ack)
    else $error("reset ack kept after request cleared");

  a_ack_wait: assert property (
    (!rst_ack && !done_s) |=> !rst_ack)
    else $error("reset ack raised before completion");

  a_por_outputs: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> pwr_req_o == `DPRR_DOM_ZERO && !wb_ack_o && wb_dat_o == `DPRR_WORD_ZERO)
    else $error("outputs not cleared by reset");

  a_wr_sel: assert property (
    (req_taken && wb_we_i && !wb_sel_i[0]) |=> pwr_req == $past(pwr_req) && rst_req == $past(rst_req))
    else $error("write without low byte enable took effect");

  a_rst_read: assert property (
    (rd && rreq_hit) |=> wb_dat_o == ($past(rst_req) ? `DPRR_DOM_ONE : `DPRR_WORD_ZERO))
    else $error("reset request readback wrong");

  a_ack_read: assert property (
    (rd && rack_hit) |=> wb_dat_o == ($past(rst_ack) ? `DPRR_DOM_ONE : `DPRR_WORD_ZERO))
    else $error("reset ack readback wrong");

  a_fid_rsvd: assert property (
    (rd && fid_hit) |=> wb_dat_o[31:6] == 26'h000_0000 && !wb_dat_o[4])
    else $error("feature word reserved bits not zero");

endmodule

// ===== tb/dprr_partner.sv
`timescale 1ns/1ps
// Behavioural power and reset controller, answers DLY cycles after a request
module dprr_partner #(
  parameter int DLY = 4
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire dprr_pkg::dprr_word_t pwr_req_i,
  input  wire dprr_pkg::dprr_word_t no_pwr_i,
  input  wire logic                 sys_rst_req_i,
  output dprr_pkg::dprr_word_t      pwr_on_o,
  output logic                      sys_rst_done_o
);
  import dprr_pkg::*;
  dprr_word_t     pipe [DLY];
  logic [DLY-1:0] rpipe;
  // Delay lines; a blocked domain never gets power
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DLY; i++) pipe[i] <= '0;
      rpipe <= '0;
    end else begin
      pipe[0] <= pwr_req_i & ~no_pwr_i;
      for (int i = 1; i < DLY; i++) pipe[i] <= pipe[i-1];
      rpipe <= {rpipe[DLY-2:0], sys_rst_req_i};
    end
  end
  assign pwr_on_o       = pipe[DLY-1];
  assign sys_rst_done_o = rpipe[DLY-1];
endmodule

// ===== tb/dprr_top_tb_top.sv
`timescale 1ns/1ps
module dprr_top_tb_top;
  import dprr_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       cyc = 1'b0;
  logic       stb = 1'b0;
  logic       we = 1'b0;
  dprr_addr_t adr = '0;
  dprr_sel_t  sel = '0;
  dprr_sel_t  wsel = 4'hf;
  dprr_word_t wdat = '0;
  dprr_word_t rdat;
  logic       ack;
  dprr_word_t pwr_req;
  dprr_word_t pwr_on;
  dprr_word_t no_pwr = '0;
  logic       rst_req;
  logic       rst_done;
  logic       dbg_en = 1'b1;
  logic       inv_en = 1'b1;
  int         num_errors = 0;
  int         n_compared = 0;

  always #20 clk_i = ~clk_i;

  dprr_top dprr_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pwr_req_o(pwr_req), .pwr_on_i(pwr_on), .sys_rst_req_o(rst_req), .sys_rst_done_i(rst_done),
    .dbg_en_i(dbg_en), .invasive_en_i(inv_en));
  dprr_partner #(.DLY(4)) dprr_partner_i (.clk_i(clk_i), .rst_i(rst_i), .pwr_req_i(pwr_req),
    .no_pwr_i(no_pwr), .sys_rst_req_i(rst_req), .pwr_on_o(pwr_on), .sys_rst_done_o(rst_done));

  task automatic complete_run();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input dprr_word_t got, input dprr_word_t exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; ack and data taken at the edge that sees ack high
  task automatic xfer(input dprr_addr_t a, input logic w, input dprr_word_t d, output dprr_word_t q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= wsel;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) chk(32'hdead_beef, 32'h0000_0000);
    @(posedge clk_i);
  endtask

  task automatic wr(input dprr_addr_t a, input dprr_word_t d);
    dprr_word_t q;
    xfer(a, 1'b1, d, q);
  endtask

  task automatic rd(input dprr_addr_t a, input dprr_word_t e);
    dprr_word_t q;
    xfer(a, 1'b0, 32'h0000_0000, q);
    chk(q, e);
  endtask

  // Poll a status word until it shows the expected code
  task automatic wait_code(input dprr_addr_t a, input dprr_word_t e);
    dprr_word_t q;
    int n;
    n = 0;
    do begin
      xfer(a, 1'b0, 32'h0000_0000, q);
      n++;
    end while (q !== e && n < 30);
    chk(q, e);
  endtask

  task automatic t_reset_vals();
    rd(12'hc18, 32'h0000_0000);
    rd(12'hc1c, 32'h0000_0000);
    rd(12'hc00, 32'h0000_0021);
    rd(12'hb0c, 32'h0000_0001);
    rd(12'hb10, 32'h0000_0000);
    rd(12'hb7c, 32'h0000_0000);
    rd(12'hb90, 32'h0000_0000);
    rd(12'hd00, 32'h0000_0000);
  endtask

  task automatic t_handshake();
    wr(12'hb04, 32'hffff_ffff);
    rd(12'hb04, 32'h0000_0003);
    chk(pwr_req, 32'h0000_0002);
    wait_code(12'hb84, 32'h0000_0003);
    chk(pwr_req, 32'h0000_0002);
    wr(12'hb04, 32'h0000_0000);
    wait_code(12'hb84, 32'h0000_0000);
    chk(pwr_req, 32'h0000_0000);
  endtask

  task automatic t_absent();
    wr(12'hb14, 32'h0000_0002);
    rd(12'hb14, 32'h0000_0000);
    chk(pwr_req, 32'h0000_0000);
    wsel = 4'he;
    wr(12'hb0c, 32'h0000_0002);
    wsel = 4'hf;
    rd(12'hb0c, 32'h0000_0001);
    chk(pwr_req, 32'h0000_0000);
  endtask

  task automatic t_no_power();
    no_pwr <= 32'h0000_0004;
    wr(12'hb08, 32'h0000_0002);
    repeat (12) @(posedge clk_i);
    rd(12'hb88, 32'h0000_0000);
    wr(12'hb08, 32'h0000_0000);
    no_pwr <= 32'h0000_0000;
  endtask

  task automatic t_dbg_off();
    dbg_en <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(12'hb0c, 32'h0000_0002);
    rd(12'hb0c, 32'h0000_0001);
    chk(pwr_req, 32'h0000_0000);
    dbg_en <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic t_sys_reset();
    inv_en <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(12'hc18, 32'h0000_0001);
    rd(12'hc18, 32'h0000_0000);
    chk({31'h0, rst_req}, 32'h0000_0000);
    inv_en <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr(12'hc18, 32'hffff_ffff);
    rd(12'hc18, 32'h0000_0001);
    wait_code(12'hc1c, 32'h0000_0001);
    rd(12'hc18, 32'h0000_0001);
    wr(12'hc18, 32'h0000_0000);
    wait_code(12'hc1c, 32'h0000_0000);
    chk({31'h0, rst_req}, 32'h0000_0000);
  endtask

  // Mid-run reset with reset and power requests standing
  task automatic t_por();
    wr(12'hc18, 32'h0000_0001);
    wait_code(12'hc1c, 32'h0000_0001);
    wr(12'hb00, 32'h0000_0002);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, rst_req}, 32'h0000_0000);
    chk(pwr_req, 32'h0000_0000);
    rd(12'hc18, 32'h0000_0000);
    rd(12'hc1c, 32'h0000_0000);
    rd(12'hb00, 32'h0000_0001);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_vals();
    t_handshake();
    t_absent();
    t_no_power();
    t_dbg_off();
    t_sys_reset();
    t_por();
    complete_run();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    complete_run();
  end
endmodule
